// file: design/ssmux_seq0_select.sv
// Sequencer 0 analog input select register with per-step routing latch.
// Operation
// - One 32-bit word holds a separate input selection for each of the eight steps of sequencer 0.
// - Step k's selection sits at bit 4k, the last at bit 28, and each applies only during its own step.
// - The selection value is the number of the analog input converted, so one routes analog input 1.
// - Bits between the fields are read-only and software leaves them unchanged when it writes.
// - Every field is read/write and resets to zero, so after reset every step selects input 0.
// - With a step's differential flag set the field is a pair number i sampling inputs 2i and 2i+1.
`timescale 1ns/1ns
module ssmux_seq0_select (
	// Clock and reset.
	input  wire logic                clk,
	input  wire logic                reset,
	// Avalon-MM slave.
	input  wire logic [11:0]         address,
	input  wire logic                read,
	input  wire logic                write,
	input  wire logic [31:0]         writedata,
	input  wire logic [3:0]          byteenable,
	output logic      [31:0]         readdata,
	output logic                     waitrequest,
	// Sequencer side.
	input  wire logic                step_start,
	input  wire logic [2:0]          step_index,
	input  wire logic                step_differential,
	output ssmux_pkg::ssmux_route_t  route,
	output logic                     route_valid
);
	ssmux_pkg::ssmux_req_t      req;
	ssmux_pkg::ssmux_bus_state_t state, next_state;
	logic [31:0]                sel_word, next_sel_word;
	logic [31:0]                readdata_q, next_readdata;
	logic                       waitrequest_q, next_waitrequest;
	ssmux_pkg::ssmux_route_t    route_q, next_route;
	logic                       route_valid_q, next_route_valid;

	// Extracts the selection of one step from the word.
	function automatic logic [3:0] step_field(input logic [31:0] word, input logic [2:0] k);
		logic [3:0] f;
		f = 4'h0;
		f[ssmux_pkg::SEL_WIDTH-1:0] = word[k*ssmux_pkg::FIELD_STRIDE +: ssmux_pkg::SEL_WIDTH];
		return f;
	endfunction

	// Expands a byte enable into a bit mask.
	function automatic logic [31:0] byte_mask(input logic [3:0] be);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{be[i]}};
		end
		return m;
	endfunction

	assign req = '{address: address, read: read, write: write, writedata: writedata, byteenable: byteenable};

	// Every access takes one answer cycle; waitrequest drops for exactly one edge.
	always_comb begin
		next_state       = state;
		next_sel_word    = sel_word;
		next_readdata    = readdata_q;
		next_waitrequest = 1'b1;
		case (state)
			ssmux_pkg::ssmux_idle: begin
				if (req.read || req.write) begin
					next_state       = ssmux_pkg::ssmux_answer;
					next_waitrequest = 1'b0;
					if (req.read) begin
						// Reserved bits read as zero.
						next_readdata = (req.address == ssmux_pkg::SEQ0_SEL_OFFSET) ?
							(sel_word & ssmux_pkg::SEQ0_SEL_WMASK) : ssmux_pkg::UNMAPPED_RDATA;
					end
				end
			end
			ssmux_pkg::ssmux_answer: begin
				next_state = ssmux_pkg::ssmux_idle;
				// The write lands at the edge where the master sees waitrequest low, not before.
				if (req.write && req.address == ssmux_pkg::SEQ0_SEL_OFFSET) begin
					// Only the selection bits store; reserved bits ignore writes.
					next_sel_word = (sel_word & ~(ssmux_pkg::SEQ0_SEL_WMASK & byte_mask(req.byteenable)))
						| (req.writedata & ssmux_pkg::SEQ0_SEL_WMASK & byte_mask(req.byteenable));
				end
			end
			default: begin
				next_state = ssmux_pkg::ssmux_idle;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state         <= ssmux_pkg::ssmux_idle;
			sel_word      <= ssmux_pkg::SEQ0_SEL_RESET;
			readdata_q    <= 32'h0000_0000;
			waitrequest_q <= 1'b1;
		end else begin
			state         <= next_state;
			sel_word      <= next_sel_word;
			readdata_q    <= next_readdata;
			waitrequest_q <= next_waitrequest;
		end
	end

	// The route is captured at step start and held, so later writes cannot disturb a running step.
	always_comb begin
		logic [3:0] f;
		f                = step_field(sel_word, step_index);
		next_route       = route_q;
		next_route_valid = 1'b0;
		if (step_start) begin
			next_route_valid        = 1'b1;
			next_route.input_sel    = f;
			next_route.differential = step_differential;
			if (step_differential) begin
				next_route.pos_input = {f[2:0], 1'b0};
				next_route.neg_input = {f[2:0], 1'b1};
			end else begin
				next_route.pos_input = f;
				next_route.neg_input = 4'h0;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			route_q       <= '0;
			route_valid_q <= 1'b0;
		end else begin
			route_q       <= next_route;
			route_valid_q <= next_route_valid;
		end
	end

	assign readdata    = readdata_q;
	assign waitrequest = waitrequest_q;
	assign route       = route_q;
	assign route_valid = route_valid_q;
endmodule

// file: design/ssmux_pkg.sv
// Package holding register map, field layout and carrier types of the sequencer 0 input select block.
package ssmux_pkg;
	localparam int          STEP_COUNT       = 8;
	localparam int          FIELD_STRIDE     = 4;
	localparam int          SEL_WIDTH        = 1;
	localparam logic [11:0] SEQ0_SEL_OFFSET  = 12'h0040;
	localparam logic [31:0] SEQ0_SEL_RESET   = 32'h0000_0000;
	localparam logic [31:0] SEQ0_SEL_WMASK   = 32'h1111_1111;
	localparam logic [31:0] UNMAPPED_RDATA   = 32'h0000_0000;
	localparam logic [3:0]  STEP_SEL_RESET   = 4'h0;

	// One Avalon-MM request as seen by the slave.
	typedef struct packed {
		logic [11:0] address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} ssmux_req_t;

	// Per-step routing handed to the analog front end.
	typedef struct packed {
		logic [3:0] input_sel;
		logic       differential;
		logic [3:0] pos_input;
		logic [3:0] neg_input;
	} ssmux_route_t;

	typedef enum logic [1:0] {
		ssmux_idle,
		ssmux_answer
	} ssmux_bus_state_t;
endpackage

// file: tb/ssmux_seq0_select_assertions.sv
// Checker of the sequencer 0 input select block.
`timescale 1ns/1ns
module ssmux_chk (
	// Watched ports.
	input wire logic clk, reset, read, write, waitrequest, step_start, step_differential, route_valid,
	input wire logic [11:0] address,
	input wire logic [31:0] writedata, readdata,
	input wire logic [3:0] byteenable,
	input wire logic [2:0] step_index,
	input wire ssmux_pkg::ssmux_route_t route
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_wait_once: assert property (!waitrequest |=> waitrequest) else $error("wait");
	a_valid_next: assert property (step_start |=> route_valid) else $error("valid");
	a_single_in: assert property (route_valid && !route.differential |->
		route.pos_input == route.input_sel && route.neg_input == 0) else $error("single");
	a_rsvd_zero: assert property ((readdata & 32'hEEEE_EEEE) == 0) else $error("rsvd");
	a_reset_clear: assert property ($fell(reset) |-> readdata == 0 && route == 0) else $error("rst");
	a_diff_pair: assert property (route_valid && route.differential |-> route.pos_input ==
		2 * route.input_sel && route.neg_input == route.pos_input + 1) else $error("pair");
	a_route_hold: assert property (!$past(step_start) |-> $stable(route)) else $error("hold");
	cover property (step_start && step_differential);
	cover property (!waitrequest && write);
	cover property (!waitrequest && read);
endmodule
bind ssmux_seq0_select ssmux_chk ssmux_chk_inst (.*);

// file: tb/ssmux_seq0_select_bench.sv
// Self-checking bench of the sequencer 0 input select block.
`timescale 1ns/1ns
module ssmux_seq0_select_bench;
	logic clk = 0, reset = 1, read = 0, write = 0, step_start = 0, step_differential = 0, waitrequest, route_valid;
	logic [11:0] address = 0;
	logic [31:0] writedata = 0, readdata, lfsr = 32'h6757_e7e7;
	logic [3:0] byteenable = 4'hF;
	logic [2:0] step_index = 0;
	ssmux_pkg::ssmux_route_t route;
	int fails = 0, checks = 0, model = 0, s;
	always #2 clk = ~clk;
	ssmux_seq0_select ssmux_seq0_select_inst (.*);
	function automatic logic [31:0] nxt(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Only enabled lanes of the field bits may change, so the model masks both.
	task automatic bus(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] b);
		logic [31:0] m;
		m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & 32'h1111_1111;
		@(posedge clk);
		{read, write, address, writedata, byteenable} <= {!w, w, a, d, b};
		do @(posedge clk); while (waitrequest !== 1'b0);
		if (w && a == 12'h040) model = model & ~m | d & m;
		if (!w) chk(readdata, a == 12'h040 ? model : 0);
		{read, write} <= 0;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		reset <= 0;
		bus(0, 12'h040, 0, 4'hF);
		$display("reset test done");
		for (int i = 0; i < 24; i++) begin
			lfsr = nxt(lfsr);
			bus(1, i == 5 ? 12'h044 : 12'h040, lfsr & 32'h1111_1111, lfsr[11:8]);
			bus(0, i == 9 ? 12'h048 : 12'h040, 0, 4'hF);
			s = model[4 * (i % 8)];
			@(posedge clk);
			{step_start, step_index, step_differential} <= {1'b1, 3'(i), lfsr[5]};
			@(posedge clk);
			step_start <= 0;
			@(negedge clk);
			chk({route_valid, route}, {1'b1, 4'(s), lfsr[5], lfsr[5] ? {4'(2 * s), 4'(2 * s + 1)} : {4'(s), 4'h0}});
		end
		$display("register and step test done");
		results;
	end
	initial begin
		#20000;
		fails++;
		results;
	end
endmodule
